/* File: touch_panel_adc_sequencing_test.sv */
// Self-checking bench for the touch panel converter sequencer
`timescale 1ns/1ps
module touch_panel_adc_sequencing_test;
  logic        clk;
  logic        resetn;
  logic        cs_n;
  logic        dclk;
  logic        din;
  logic        dout;
  logic        busy;
  logic [11:0] adc_sample;
  logic        panel_pressed;
  logic        drive_x;
  logic        drive_y;
  logic        acq;
  logic        pen_touch_irq_o;
  logic        pen_touch_irq_oe_n;
  logic        powered_dn;
  logic [11:0] exp_q [$];
  int          fails;
  int          tests_run;
  int          w;

  tpc_seq u_tpc_seq (.clk(clk), .resetn(resetn), .cs_n(cs_n), .dclk(dclk), .din(din),
    .dout(dout), .busy(busy), .adc_sample(adc_sample), .panel_pressed(panel_pressed),
    .drive_x(drive_x), .drive_y(drive_y), .acq(acq), .pen_touch_irq_o(pen_touch_irq_o),
    .pen_touch_irq_oe_n(pen_touch_irq_oe_n), .powered_dn(powered_dn));

  tpc_host_model u_tpc_host_model (.clk(clk), .cs_n(cs_n), .dclk(dclk), .din(din),
    .dout(dout), .acq(acq), .drive_x(drive_x), .drive_y(drive_y), .res_data());

  // System clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input string name, input logic [11:0] e, input logic [11:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic finish_test();
    if (exp_q.size() != 0) fails++;
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each result read back is matched against the oldest note
  always begin
    @(u_tpc_host_model.res_ev);
    if (exp_q.size() == 0) check("spare_result", 12'h001, 12'h000);
    else check("result", exp_q.pop_front(), u_tpc_host_model.res_data);
  end

  // One frame; p6, p14 are {acq,x,y} after those rises, pend {x,y,pdn} at end
  // Commands gap clocks apart; ext stretches each acquisition clock
  task automatic run(input logic [15:0] cmds, input int n, input int gap, input int ext,
                     input logic [2:0] p6, input logic [2:0] p14, input logic [2:0] pend);
    int t;
    t = gap * (n - 1) + 21;
    adc_sample = 12'($urandom);
    for (int i = 0; i < n; i++) exp_q.push_back(adc_sample);
    u_tpc_host_model.xfer(cmds, n, gap, ext);
    check("acq_edges", 12'h006, {8'h00, u_tpc_host_model.log_q[4][2],
      u_tpc_host_model.log_q[5][2], u_tpc_host_model.log_q[7][2],
      u_tpc_host_model.log_q[8][2]});
    check("acq_len", 12'(n * (24 + 3 * ext)), 12'(u_tpc_host_model.acq_cnt));
    check("acquire", {9'h000, p6}, {9'h000, u_tpc_host_model.log_q[6]});
    check("convert", {9'h000, p14}, {9'h000, u_tpc_host_model.log_q[14]});
    check("end", {9'h000, pend}, {9'h000, u_tpc_host_model.log_q[t][1:0], powered_dn});
    if (n == 2) check("held", 12'h001, {11'h000, u_tpc_host_model.log_q[22][0]});
    if (n == 2) check("kept", 12'h001, {11'h000, u_tpc_host_model.log_q[20][0]});
    if (n == 2) check("settled", adc_sample, u_tpc_host_model.res_data);
    if (n == 2) check("agree", u_tpc_host_model.sh[0], u_tpc_host_model.sh[1]);
    u_tpc_host_model.deselect();
  endtask

  // Cuts a hang short
  initial begin
    #500_000;
    fails++;
    finish_test();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    panel_pressed = 1'b0;
    adc_sample = 12'h000;
    void'($urandom(32'h27d7));
    repeat (5) @(negedge clk);
    check("reset", 12'h001, {5'h00, dout, busy, drive_x, drive_y, acq, powered_dn,
      pen_touch_irq_oe_n});
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    run(16'h0093, 1, 12, 0, 3'b101, 3'b001, 3'b010);
    run(16'h00d4, 1, 12, 0, 3'b110, 3'b000, 3'b001);
    run(16'h00b0, 1, 12, 4, 3'b100, 3'b000, 3'b001);
    run(16'h9090, 2, 12, 0, 3'b101, 3'b001, 3'b001);
    run(16'h9090, 2, 16, 0, 3'b101, 3'b001, 3'b001);
    run(16'h0090, 1, 12, 0, 3'b101, 3'b001, 3'b001);
    check("pen_idle", 12'h001, {10'h000, pen_touch_irq_o, pen_touch_irq_oe_n});
    panel_pressed = 1'b1;
    w = 0;
    while (pen_touch_irq_oe_n !== 1'b0 && w < 20) begin
      @(negedge clk);
      w++;
    end
    if (w == 20) begin
      fails++;
      finish_test();
    end
    check("pen_low", 12'h000, {10'h000, pen_touch_irq_o, pen_touch_irq_oe_n});
    run(16'h00d4, 1, 12, 0, 3'b110, 3'b000, 3'b001);
    panel_pressed = 1'b0;
    repeat (8) @(negedge clk);
    check("pen_free", 12'h001, {10'h000, pen_touch_irq_o, pen_touch_irq_oe_n});
    finish_test();
  end
endmodule // touch_panel_adc_sequencing_test

/* File: tpc_cmd_rx.sv */
// Command byte receiver: finds the start bit and counts serial clocks
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_cmd_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link to the sequencer
  tpc_if.rx        lk
);

  // Bit position: 0 waits for start bit, 1..8 counts command clocks
  always_ff @(posedge clk) begin
    if (!resetn || !lk.cs_act) begin
      lk.pos <= 4'h0;
    end else if (lk.rise) begin
      if (lk.pos == 4'h0 || lk.pos == `TPC_POS_LAST) begin
        lk.pos <= lk.din ? 4'h1 : 4'h0;
      end else begin
        lk.pos <= lk.pos + 4'h1;
      end
    end
  end

  // Command bits after the start bit, first bit ends up highest
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lk.sh <= 7'h00;
    end else if (lk.rise && lk.cs_act && lk.pos != 4'h0 && lk.pos != `TPC_POS_LAST) begin
      lk.sh <= {lk.sh[5:0], lk.din};
    end
  end

  // Step follows the rise so the sequencer sees the new position
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lk.step <= 1'b0;
    end else begin
      lk.step <= lk.rise && lk.cs_act;
    end
  end

endmodule // tpc_cmd_rx

/* File: tpc_defines.svh */
// Constants for the touch panel converter sequencer
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_POS_CHAN   4'h4
`define TPC_POS_ACQ    4'h5
`define TPC_POS_LAST   4'h8
`define TPC_CONV_BITS  4'hC
`define TPC_ACQ_CLKS   4'h3
`define TPC_RES_W      12
`define TPC_CH_Y       3'h1
`define TPC_CH_X       3'h5
`define TPC_PD_IRQ     2'h0
`define TPC_SER_BIT    2
`define TPC_PD_HI_BIT  1
`define TPC_PD_LO_BIT  0
`endif

/* File: tpc_host_model.sv */
// Host model: drives the serial link, reads results, logs pin states
`timescale 1ns/1ps
module tpc_host_model (
  // Clock
  input  wire logic        clk,
  // Serial link
  output logic             cs_n,
  output logic             dclk,
  output logic             din,
  input  wire logic        dout,
  // Observed analog side
  input  wire logic        acq,
  input  wire logic        drive_x,
  input  wire logic        drive_y,
  // Last result read back
  output logic [11:0]      res_data
);
  logic [2:0]  log_q [0:40];
  logic [11:0] sh    [0:1];
  int          acq_cnt;
  event        res_ev;

  // Link idles deselected with its clock standing low
  initial begin
    cs_n = 1'b1;
    dclk = 1'b0;
    din  = 1'b0;
  end

  // Sample switch time in system clocks
  always @(posedge clk) begin
    if (acq === 1'b1) acq_cnt++;
  end

  // Commands gap clocks apart, so the next one overlaps a conversion
  task automatic xfer(input logic [15:0] cmds, input int n, input int gap, input int ext);
    int t;
    int k;
    int h;
    t = gap * (n - 1) + 21;
    acq_cnt = 0;
    cs_n = 1'b0;
    for (int r = 1; r <= t; r++) begin
      k = (r - 1) / gap;
      din = 1'b0; // Zero outside command bits, else a false start bit
      if (k < n && (r - 1) % gap < 8) din = cmds[8 * (n - 1 - k) + 7 - (r - 1) % gap];
      // Low half before clocks six to eight stretched by ext for settling
      h = (k < n && (r - 1) % gap >= 5 && (r - 1) % gap <= 7) ? 4 + ext : 4;
      repeat (h) @(negedge clk);
      log_q[r - 1] = {acq, drive_x, drive_y};
      dclk = 1'b1;
      repeat (4) @(negedge clk);
      for (int j = 0; j < n; j++) begin
        if (r >= gap * j + 9 && r <= gap * j + 20) sh[j] = {sh[j][10:0], dout};
        if (r == gap * j + 20) begin
          res_data = sh[j];
          -> res_ev;
        end
      end
      dclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    log_q[t] = {acq, drive_x, drive_y};
  endtask

  // Deselect ends the frame
  task automatic deselect();
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // tpc_host_model

/* File: tpc_if.sv */
// Carrier between the sequencer and its command receiver
`timescale 1ns/1ps
interface tpc_if;
  logic       rise;
  logic       din;
  logic       cs_act;
  logic       step;
  logic [3:0] pos;
  logic [6:0] sh;
  modport rx  (input rise, din, cs_act, output step, pos, sh);
  modport seq (input step, pos, sh, output rise, din, cs_act);
endinterface

/* File: tpc_pkg.sv */
// Types shared by the touch panel converter sequencer
package tpc_pkg;
  typedef enum logic [3:0] {
    TPC_DRV_IDLE = 4'b0001,
    TPC_DRV_ACQ  = 4'b0010,
    TPC_DRV_HOLD = 4'b0100,
    TPC_DRV_PDN  = 4'b1000
  } tpc_drv_t;
endpackage

/* File: tpc_seq.sv */
// Touch panel converter sequencer: drivers, acquisition, result, pen
//
// How it works
// - Ratiometric: same channel requested during conversion keeps drivers on afterwards.
// - Single-ended: drivers go off during conversions.
// - Ratiometric: drivers stay on across conversions until power-down is commanded.
// - Input is sampled during serial clocks six, seven and eight only.
// - Power-down field 00 enters power-down with pen interrupt enabled.
// - Channel 001 drives the Y axis for a Y conversion.
// - Powered down: pen output released when untouched, pulled low when pressed.
// - After a conversion the device may power down until the next one.
// - Single-ended: drivers on from acquisition start, off when conversion starts.
// - Ratiometric: drivers on from acquisition start to a conversion end with power-down field 00.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_seq (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Serial link pins
  input  wire logic                  cs_n,
  input  wire logic                  dclk,
  input  wire logic                  din,
  output logic                       dout,
  output logic                       busy,
  // Analog side
  input  wire logic [`TPC_RES_W-1:0] adc_sample,
  input  wire logic                  panel_pressed,
  output logic                       drive_x,
  output logic                       drive_y,
  output logic                       acq,
  // Pen touch open-drain pin
  output logic                       pen_touch_irq_o,
  output logic                       pen_touch_irq_oe_n,
  // Status
  output logic                       powered_dn
);

  tpc_if lk ();
  tpc_pkg::tpc_drv_t state;
  tpc_pkg::tpc_drv_t next_state;

  logic [1:0]            cs_sy;
  logic [2:0]            dclk_sy;
  logic [1:0]            din_sy;
  logic [1:0]            pen_sy;
  logic [`TPC_RES_W-1:0] adc_m;
  logic [`TPC_RES_W-1:0] adc_s;
  logic [`TPC_RES_W-1:0] result;
  logic [3:0]            conv_cnt;
  logic [2:0]            chan_act;
  logic [1:0]            pd_act;
  logic                  fall;
  logic                  cmd_done;
  logic                  acq_start;
  logic                  conv_end;
  logic                  keep;

  // Channel bits sit just above the newest bits once they are in
  function automatic logic [2:0] tpc_chan(input logic [6:0] sh, input logic [3:0] pos);
    logic [6:0] t;
    t = sh >> (pos - `TPC_POS_CHAN);
    return t[2:0];
  endfunction

  tpc_cmd_rx u_rx (
    .clk    (clk),
    .resetn (resetn),
    .lk     (lk)
  );

  // Two flops on every pin; third dclk flop only feeds edge detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_sy   <= 2'h3;
      dclk_sy <= 3'h0;
      din_sy  <= 2'h0;
      pen_sy  <= 2'h0;
      adc_m   <= 12'h000;
      adc_s   <= 12'h000;
    end else begin
      cs_sy   <= {cs_sy[0], cs_n};
      dclk_sy <= {dclk_sy[1:0], dclk};
      din_sy  <= {din_sy[0], din};
      pen_sy  <= {pen_sy[0], panel_pressed};
      adc_m   <= adc_sample;
      adc_s   <= adc_m;
    end
  end

  assign lk.rise   = dclk_sy[1] & ~dclk_sy[2];
  assign lk.din    = din_sy[1];
  assign lk.cs_act = ~cs_sy[1];
  assign fall      = ~dclk_sy[1] & dclk_sy[2];

  // Events seen one cycle after each serial rising edge
  assign acq_start = lk.step && lk.pos == `TPC_POS_ACQ;
  assign cmd_done  = lk.step && lk.pos == `TPC_POS_LAST;
  assign conv_end  = lk.step && conv_cnt == `TPC_CONV_BITS;
  // Overlapped command for the same channel holds the panel
  assign keep = lk.pos >= `TPC_POS_CHAN && lk.pos < `TPC_POS_LAST
                && tpc_chan(lk.sh, lk.pos) == chan_act;

  // Fields of the finished command; power-down field kept while the next one shifts in, channel until its acquisition start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chan_act <= 3'h0;
      pd_act   <= 2'h3;
    end else if (acq_start) begin
      chan_act <= tpc_chan(lk.sh, lk.pos);
    end else if (cmd_done) begin
      pd_act   <= {lk.sh[`TPC_PD_HI_BIT], lk.sh[`TPC_PD_LO_BIT]};
    end
  end

  // Driver state decisions
  always_comb begin
    next_state = state;
    case (state)
      tpc_pkg::TPC_DRV_IDLE, tpc_pkg::TPC_DRV_PDN: begin
        if (acq_start) begin
          next_state = tpc_pkg::TPC_DRV_ACQ;
        end else if (conv_end && pd_act == `TPC_PD_IRQ) begin
          next_state = tpc_pkg::TPC_DRV_PDN;
        end
      end
      tpc_pkg::TPC_DRV_ACQ: begin
        if (!lk.cs_act) begin
          next_state = tpc_pkg::TPC_DRV_IDLE;
        end else if (cmd_done) begin
          // Single-ended lets go at conversion start
          next_state = lk.sh[`TPC_SER_BIT] ? tpc_pkg::TPC_DRV_IDLE
                                           : tpc_pkg::TPC_DRV_HOLD;
        end
      end
      tpc_pkg::TPC_DRV_HOLD: begin
        if (acq_start) begin
          next_state = tpc_pkg::TPC_DRV_ACQ;
        end else if (conv_end && !keep && pd_act == `TPC_PD_IRQ) begin
          next_state = tpc_pkg::TPC_DRV_PDN;
        end
      end
      default: begin
        next_state = tpc_pkg::TPC_DRV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= tpc_pkg::TPC_DRV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Panel drivers and sample switch, registered off the next state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      drive_x    <= 1'b0;
      drive_y    <= 1'b0;
      acq        <= 1'b0;
      powered_dn <= 1'b0;
    end else begin
      drive_y    <= (next_state == tpc_pkg::TPC_DRV_ACQ || next_state == tpc_pkg::TPC_DRV_HOLD)
                    && (acq_start ? tpc_chan(lk.sh, lk.pos) : chan_act) == `TPC_CH_Y;
      drive_x    <= (next_state == tpc_pkg::TPC_DRV_ACQ || next_state == tpc_pkg::TPC_DRV_HOLD)
                    && (acq_start ? tpc_chan(lk.sh, lk.pos) : chan_act) == `TPC_CH_X;
      acq        <= next_state == tpc_pkg::TPC_DRV_ACQ;
      powered_dn <= next_state == tpc_pkg::TPC_DRV_PDN;
    end
  end

  // Conversion: sample held at clock eight, twelve bits shifted out
  always_ff @(posedge clk) begin
    if (!resetn || !lk.cs_act) begin
      conv_cnt <= 4'h0;
    end else if (cmd_done) begin
      conv_cnt <= 4'h1;
    end else if (conv_end) begin
      conv_cnt <= 4'h0;
    end else if (lk.step && conv_cnt != 4'h0) begin
      conv_cnt <= conv_cnt + 4'h1;
    end
  end

  // Result latch and serial output, MSB first on falling edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result <= 12'h000;
      dout   <= 1'b0;
      busy   <= 1'b0;
    end else begin
      if (cmd_done) begin
        result <= adc_s;
      end
      if (cmd_done) begin
        busy <= 1'b1;
      end else if (fall || !lk.cs_act) begin
        busy <= 1'b0;
      end
      if (!lk.cs_act) begin
        dout <= 1'b0;
      end else if (fall && conv_cnt != 4'h0) begin
        dout <= result[`TPC_CONV_BITS - conv_cnt];
      end
    end
  end

  // Pen pin: only pulls low, the outside pull-up gives the high
  assign pen_touch_irq_o = 1'b0;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pen_touch_irq_oe_n <= 1'b1;
    end else begin
      pen_touch_irq_oe_n <= ~(powered_dn & pen_sy[1]);
    end
  end

  // Helper: serial steps counted while acquiring
  logic [3:0] acq_steps;
  always_ff @(posedge clk) begin
    if (!resetn || !acq) begin
      acq_steps <= 4'h0;
    end else if (lk.step) begin
      acq_steps <= acq_steps + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_acq_len;
    $fell(acq) && lk.cs_act |-> acq_steps == `TPC_ACQ_CLKS;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition not three clocks");

  property p_se_off;
    cmd_done && lk.sh[`TPC_SER_BIT] |=> !drive_x && !drive_y && !acq;
  endproperty
  a_se_off: assert property (p_se_off) else $error("single-ended drivers stayed on");

  property p_diff_on;
    cmd_done && !lk.sh[`TPC_SER_BIT] && state == tpc_pkg::TPC_DRV_ACQ && lk.cs_act
      |=> state == tpc_pkg::TPC_DRV_HOLD && !acq;
  endproperty
  a_diff_on: assert property (p_diff_on) else $error("ratiometric drivers dropped");

  property p_y_axis;
    state == tpc_pkg::TPC_DRV_HOLD && chan_act == `TPC_CH_Y |-> drive_y && !drive_x;
  endproperty
  a_y_axis: assert property (p_y_axis) else $error("Y channel not driving Y");

  property p_pen_low;
    powered_dn && pen_sy[1] |=> !pen_touch_irq_oe_n;
  endproperty
  a_pen_low: assert property (p_pen_low) else $error("pen press not pulled low");

  property p_pen_rel;
    !powered_dn || !pen_sy[1] |=> pen_touch_irq_oe_n;
  endproperty
  a_pen_rel: assert property (p_pen_rel) else $error("pen pin driven when idle");

  property p_keep;
    conv_end && keep && state == tpc_pkg::TPC_DRV_HOLD |=> ##1 !powered_dn;
  endproperty
  a_keep: assert property (p_keep) else $error("same channel did not hold panel");

  property p_pdn;
    conv_end && !keep && pd_act == `TPC_PD_IRQ && !acq_start && state != tpc_pkg::TPC_DRV_ACQ
      |=> ##1 powered_dn && !drive_y;
  endproperty
  a_pdn: assert property (p_pdn) else $error("no power-down on 00");

  property p_diff_stay;
    conv_end && state == tpc_pkg::TPC_DRV_HOLD && pd_act != `TPC_PD_IRQ && !acq_start
      |=> state == tpc_pkg::TPC_DRV_HOLD;
  endproperty
  a_diff_stay: assert property (p_diff_stay) else $error("ratiometric hold lost");

  c_conv: cover property (conv_end);
  c_keep: cover property (conv_end && keep && state == tpc_pkg::TPC_DRV_HOLD);
  c_pen:  cover property (powered_dn && !pen_touch_irq_oe_n);

endmodule // tpc_seq
